// *** core/ivlc_core.v ***
// Interrupt vector address forming and repeat-loop context save/restore
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ivlc_map.vh"

module ivlc_core #(
    parameter PAGE_W = 16,
    parameter VEC_W  = 5
) (
    // Clock and reset
    input  wire                    CORE_CLK_IN,
    input  wire                    RST_IN,
    // Register port
    input  wire [1:0]              REG_ADDR_IN,
    input  wire [15:0]             REG_WDATA_IN,
    input  wire                    REG_WR_IN,
    input  wire                    REG_RD_IN,
    output reg  [15:0]             REG_RDATA_OUT,
    // Program flow events
    input  wire                    FLOW_ENTER_IN,
    input  wire                    FLOW_RETURN_IN,
    input  wire                    SOFT_RESET_IN,
    // Live loop status set by the repeat logic
    input  wire                    LOOP_SET_IN,
    input  wire [7:0]              LOOP_SET_VALUE_IN,
    output reg  [7:0]              LOOP_LIVE_OUT,
    // Vector request
    input  wire                    VEC_REQ_IN,
    input  wire [VEC_W-1:0]        VEC_NUM_IN,
    output reg  [PAGE_W+VEC_W+2:0] VEC_ADDR_OUT,
    output reg                     VEC_VALID_OUT,
    output reg                     VEC_MASKABLE_OUT,
    output reg                     VEC_SW_ONLY_OUT
);

    ////////////////////////////////////////////////////////////////////
    // Storage

    reg [PAGE_W-1:0] primary_vector_page_reg;
    reg [PAGE_W-1:0] high_vector_page_reg;
    reg [7:0]        loop_context_save_reg;
    reg [7:0]        loop_context_save_next;
    reg [7:0]        loop_live_next;
    reg [PAGE_W-1:0] sel_page;
    wire             use_high;
    wire             wr_primary;
    wire             wr_high;
    wire             wr_context;
    wire             wr_live;

    assign wr_primary = REG_WR_IN && (REG_ADDR_IN == `IVLC_ADDR_PRIMARY_PAGE);
    assign wr_high    = REG_WR_IN && (REG_ADDR_IN == `IVLC_ADDR_HIGH_PAGE);
    assign wr_context = REG_WR_IN && (REG_ADDR_IN == `IVLC_ADDR_LOOP_CONTEXT);
    assign wr_live    = REG_WR_IN && (REG_ADDR_IN == `IVLC_ADDR_LOOP_LIVE);

    ////////////////////////////////////////////////////////////////////
    // Vector page pointers

    // Soft reset has no term here on purpose: pointers survive it
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            primary_vector_page_reg <= `IVLC_PAGE_RESET;
            high_vector_page_reg    <= `IVLC_PAGE_RESET;
        end else begin
            // Updated regardless of SOFT_RESET_IN
            if (wr_primary) begin
                primary_vector_page_reg <= REG_WDATA_IN[PAGE_W-1:0];
            end
            if (wr_high) begin
                high_vector_page_reg <= REG_WDATA_IN[PAGE_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Loop context save and live status

    // Priority: flow event over a software write; a return loads the
    // live status, an enter saves it and wins over a same-cycle return; both read old values.
    always @* begin
        loop_context_save_next = loop_context_save_reg;
        loop_live_next         = LOOP_LIVE_OUT;
        if (LOOP_SET_IN) begin
            loop_live_next = LOOP_SET_VALUE_IN & `IVLC_CONTEXT_MASK;
        end
        if (wr_live) begin
            loop_live_next = REG_WDATA_IN[7:0] & `IVLC_CONTEXT_MASK;
        end
        if (wr_context) begin
            // Reserved bits 5..4 never stored
            loop_context_save_next = REG_WDATA_IN[7:0] & `IVLC_CONTEXT_MASK;
        end
        if (FLOW_ENTER_IN) begin
            loop_context_save_next = LOOP_LIVE_OUT;
        end else if (FLOW_RETURN_IN) begin
            loop_live_next = loop_context_save_reg;
        end
    end

    // Bit 7 single, bit 6 conditional, bits 3..0 two block levels
    // are carried as packed
    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            loop_context_save_reg <= `IVLC_CONTEXT_RESET;
            LOOP_LIVE_OUT         <= `IVLC_CONTEXT_RESET;
        end else begin
            loop_context_save_reg <= loop_context_save_next;
            LOOP_LIVE_OUT         <= loop_live_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read port

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 16'h0000;
        end else if (REG_RD_IN) begin
            if (REG_ADDR_IN == `IVLC_ADDR_PRIMARY_PAGE) begin
                REG_RDATA_OUT <= primary_vector_page_reg;
            end else if (REG_ADDR_IN == `IVLC_ADDR_HIGH_PAGE) begin
                REG_RDATA_OUT <= high_vector_page_reg;
            end else if (REG_ADDR_IN == `IVLC_ADDR_LOOP_CONTEXT) begin
                REG_RDATA_OUT <= {8'h00, loop_context_save_reg};
            end else begin
                REG_RDATA_OUT <= {8'h00, LOOP_LIVE_OUT};
            end
        end else begin
            REG_RDATA_OUT <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Vector address forming

    // Software is expected to mask interrupts while pages change; the
    // address uses whatever page is held at request time
    assign use_high = (VEC_NUM_IN >= `IVLC_HIGH_FIRST) &&
                      (VEC_NUM_IN <= `IVLC_HIGH_LAST);

    always @* begin
        if (use_high) begin
            sel_page = high_vector_page_reg;
        end else begin
            sel_page = primary_vector_page_reg;
        end
    end

    always @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            VEC_ADDR_OUT     <= {(PAGE_W+VEC_W+3){1'b0}};
            VEC_VALID_OUT    <= 1'b0;
            VEC_MASKABLE_OUT <= 1'b0;
            VEC_SW_ONLY_OUT  <= 1'b0;
        end else begin
            VEC_VALID_OUT <= VEC_REQ_IN;
            if (VEC_REQ_IN) begin
                // Plain binary index, low three bits zero
                VEC_ADDR_OUT <= {sel_page, VEC_NUM_IN, 3'b000};
                // Roles by number
                VEC_MASKABLE_OUT <= (VEC_NUM_IN != `IVLC_VEC_RESET) &&
                                    (VEC_NUM_IN != `IVLC_VEC_NMI) &&
                                    (VEC_NUM_IN < `IVLC_VEC_SW_FIRST);
                VEC_SW_ONLY_OUT  <= (VEC_NUM_IN >= `IVLC_VEC_SW_FIRST);
            end
        end
    end

endmodule
`default_nettype wire

// *** core/ivlc_map.vh ***
// Constants for the interrupt vector and loop context block
`ifndef IVLC_MAP_VH
`define IVLC_MAP_VH

// Register indices on the plain register port
`define IVLC_ADDR_PRIMARY_PAGE   2'h0
`define IVLC_ADDR_HIGH_PAGE      2'h1
`define IVLC_ADDR_LOOP_CONTEXT   2'h2
`define IVLC_ADDR_LOOP_LIVE      2'h3

// Reset values
`define IVLC_PAGE_RESET          16'hffff
`define IVLC_CONTEXT_RESET       8'h00

// Loop context field positions
`define IVLC_BIT_SINGLE_RPT      7
`define IVLC_BIT_COND_RPT        6
`define IVLC_RSVD_HI             5
`define IVLC_RSVD_LO             4
`define IVLC_BLK_HI              3
`define IVLC_BLK_LO              0
`define IVLC_CONTEXT_MASK        8'hcf

// Block-repeat level state codes, two bits per level
`define IVLC_BLK_INACTIVE        2'h0
`define IVLC_BLK_LOCAL           2'h1
`define IVLC_BLK_EXTERNAL        2'h2

// Vector number ranges that use the high page
`define IVLC_HIGH_FIRST          5'h10
`define IVLC_HIGH_LAST           5'h17

// Vector roles
`define IVLC_VEC_RESET           5'h00
`define IVLC_VEC_NMI             5'h01
`define IVLC_VEC_BUS_FAULT       5'h18
`define IVLC_VEC_TRACE_LOG       5'h19
`define IVLC_VEC_OS_SERVICE      5'h1a
`define IVLC_VEC_SW_FIRST        5'h1b

`endif

// *** test/ivlc_core_checker.sv ***
// Port assertions for the vector and loop context block
`timescale 1ns/1ps
`default_nettype none
`include "ivlc_map.vh"
module ivlc_core_checker #(parameter PAGE_W = 16, parameter VEC_W = 5) (
    input wire logic                    CORE_CLK_IN, RST_IN,
    input wire logic                    REG_RD_IN, REG_WR_IN,
    input wire logic [1:0]              REG_ADDR_IN,
    input wire logic [15:0]             REG_RDATA_OUT,
    input wire logic                    FLOW_ENTER_IN, FLOW_RETURN_IN,
    input wire logic                    SOFT_RESET_IN, LOOP_SET_IN,
    input wire logic [7:0]              LOOP_SET_VALUE_IN, LOOP_LIVE_OUT,
    input wire logic                    VEC_REQ_IN,
    input wire logic [VEC_W-1:0]        VEC_NUM_IN,
    input wire logic [PAGE_W+VEC_W+2:0] VEC_ADDR_OUT,
    input wire logic                    VEC_VALID_OUT, VEC_MASKABLE_OUT,
    input wire logic                    VEC_SW_ONLY_OUT
);
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    // A write to the live status slot also moves the live value
    wire quiet = !FLOW_ENTER_IN && !FLOW_RETURN_IN &&
        !(REG_WR_IN && REG_ADDR_IN == `IVLC_ADDR_LOOP_LIVE);
    a_vec_valid: assert property (VEC_REQ_IN |=> VEC_VALID_OUT)
        else $error("vector valid missing");
    a_vec_number: assert property (VEC_REQ_IN |=> VEC_ADDR_OUT[7:0] ==
        {$past(VEC_NUM_IN), 3'h0}) else $error("vector low bits wrong");
    a_vec_hold: assert property (!VEC_REQ_IN |=> $stable(VEC_ADDR_OUT)
        && !VEC_VALID_OUT) else $error("vector output moved");
    a_mask_flag: assert property (VEC_REQ_IN |=> VEC_MASKABLE_OUT ==
        ($past(VEC_NUM_IN) >= 5'h02 && $past(VEC_NUM_IN) <= 5'h1a))
        else $error("maskable flag wrong");
    a_sw_flag: assert property (VEC_REQ_IN |=> VEC_SW_ONLY_OUT ==
        ($past(VEC_NUM_IN) >= `IVLC_VEC_SW_FIRST)) else $error("sw flag wrong");
    a_live_load: assert property (LOOP_SET_IN && quiet |=> LOOP_LIVE_OUT ==
        ($past(LOOP_SET_VALUE_IN) & `IVLC_CONTEXT_MASK)) else $error("live load");
    a_ctx_round: assert property (FLOW_ENTER_IN ##1 (FLOW_RETURN_IN &&
        !FLOW_ENTER_IN) |=> LOOP_LIVE_OUT == $past(LOOP_LIVE_OUT, 2))
        else $error("context not restored");
    a_rsvd_zero: assert property (REG_RD_IN && REG_ADDR_IN[1] |=>
        REG_RDATA_OUT[15:8] == 8'h00 && REG_RDATA_OUT[5:4] == 2'h0)
        else $error("reserved bits set");
    a_soft_keep: assert property (SOFT_RESET_IN && quiet && !LOOP_SET_IN
        |=> $stable(LOOP_LIVE_OUT)) else $error("soft reset moved live");
    c_round: cover property (FLOW_ENTER_IN ##1 FLOW_RETURN_IN);
    c_high: cover property (VEC_REQ_IN && VEC_NUM_IN == `IVLC_HIGH_LAST);
    c_write: cover property (REG_WR_IN && REG_ADDR_IN == `IVLC_ADDR_LOOP_CONTEXT);
endmodule
bind ivlc_core ivlc_core_checker #(.PAGE_W(PAGE_W), .VEC_W(VEC_W)) ivlc_core_checker_i (.*);
`default_nettype wire

// *** test/test_interrupt_vector_and_loop_context.sv ***
// Self-checking bench for the vector and loop context block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module test_interrupt_vector_and_loop_context;
    logic c = 0, r = 1, we = 0, re = 0, fe = 0, fr = 0, sr = 0, ls = 0, vr = 0;
    logic [1:0]  a = 0;
    logic [15:0] wd = 0, pg [2];
    logic [7:0]  lv = 0, sv = 0, lvm = 0, v;
    logic [4:0]  vn = 0;
    wire  [15:0] rdat;
    wire  [7:0]  live;
    wire  [23:0] va;
    wire         vv, vm, vs;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    always #12.5 c = ~c;
    ivlc_core ivlc_core_i (.CORE_CLK_IN(c), .RST_IN(r), .REG_ADDR_IN(a),
        .REG_WDATA_IN(wd), .REG_WR_IN(we), .REG_RD_IN(re), .REG_RDATA_OUT(rdat),
        .FLOW_ENTER_IN(fe), .FLOW_RETURN_IN(fr), .SOFT_RESET_IN(sr),
        .LOOP_SET_IN(ls), .LOOP_SET_VALUE_IN(lv), .LOOP_LIVE_OUT(live),
        .VEC_REQ_IN(vr), .VEC_NUM_IN(vn), .VEC_ADDR_OUT(va),
        .VEC_VALID_OUT(vv), .VEC_MASKABLE_OUT(vm), .VEC_SW_ONLY_OUT(vs));
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [1:0] ad, input logic [15:0] d);
        if (ad < 2) pg[ad[0]] = d;
        else if (ad == 2) sv = d[7:0] & 8'hcf;
        else lvm = d[7:0] & 8'hcf;
        @(posedge c); a <= ad; wd <= d; we <= 1'b1;
        @(posedge c); we <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] ad, input logic [15:0] e);
        @(posedge c); a <= ad; re <= 1'b1;
        @(posedge c); re <= 1'b0;
        #1 `CHK("rdata", e, rdat)
    endtask
    // s holds enter, return, soft reset and loop set, in that order
    task automatic step(input logic [3:0] s, input logic [7:0] d);
        if (s[3]) sv = lvm;
        else if (s[2]) lvm = sv;
        else if (s[0]) lvm = d & 8'hcf;
        @(posedge c); {fe, fr, sr, ls} <= s; lv <= d;
        @(posedge c); {fe, fr, sr, ls} <= 4'h0;
        #1 `CHK("live", lvm, live)
    endtask
    task automatic vec(input logic [4:0] n);
        @(posedge c); vr <= 1'b1; vn <= n;
        @(posedge c); vr <= 1'b0;
        #1 `CHK("addr", {(n >= 16 && n <= 23) ? pg[1] : pg[0], n, 3'h0}, va)
        `CHK("flags", {1'b1, n >= 2 && n <= 26, n >= 27}, {vv, vm, vs})
    endtask
    always @(posedge c) begin
        cyc++;
        // Whole run needs well under a thousand cycles
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        void'($urandom(81));
        pg[0] = 16'hffff;
        pg[1] = 16'hffff;
        repeat (6) @(posedge c);
        r <= 1'b0;
        for (int i = 0; i < 4; i++) rd(i, i < 2 ? 16'hffff : 16'h0);
        $display("reset values done");
        // No vector request overlaps a page change here
        for (int i = 0; i < 2; i++) wr(i, $urandom);
        for (int n = 0; n < 32; n++) vec(n);
        $display("vector addresses done");
        step(4'h2, 8'h00);
        rd(0, pg[0]);
        rd(1, pg[1]);
        rd(2, {8'h0, sv});
        // Every outer and inner block code with random single and conditional repeat bits
        for (int i = 0; i < 9; i++) begin
            v = $urandom;
            v[3:0] = {2'(i / 3), 2'(i % 3)};
            step(4'h1, v);
            step(4'h8, 8'h00);
            step(4'h1, v ^ 8'hc0);
            rd(2, {8'h0, sv});
            rd(3, {8'h0, lvm});
            step(4'h4, 8'h00);
        end
        wr(2, 16'hffff);
        rd(2, 16'h00cf);
        step(4'h4, 8'h00);
        wr(3, $urandom);
        rd(3, {8'h0, lvm});
        // Enter then return on adjacent edges must give back the live value
        sv = lvm;
        @(posedge c); fe <= 1'b1;
        @(posedge c); fe <= 1'b0; fr <= 1'b1;
        @(posedge c); fr <= 1'b0;
        #1 `CHK("round", lvm, live)
        rd(2, {8'h0, sv});
        $display("loop context done");
        final_report();
    end
endmodule
`default_nettype wire
